/* rtl/ctab_tx_ctrl.sv */
`timescale 1ns/1ps
// Functional notes
// R1: Three empty flags in bits 2..0; one means empty and unscheduled.
// R2: Outside init, writing one clears an empty flag; zero ignored; always readable.
// R3: Software loads a buffer first, then clears its empty flag.
// R4: Successful send sets the buffer's empty flag.
// R5: A granted withdraw also sets the empty flag.
// R6: Interrupt asserted while any enabled buffer is empty.
// R7: Clearing an empty flag clears that buffer's withdraw ack.
// R8: Setting an empty flag clears that buffer's withdraw request.
// R9: Listen mode ignores flag clears and starts no transmission.
// R10: Buffer content access blocked while scheduled.
// R11: Init mode holds all four registers at reset values.
// R12: Writes accepted only when init request and acknowledge both zero; the mode register is written in any mode.
// R13: Enable zero suppresses, one lets the empty event request interrupt.
// R14: Software withdraws by setting request on a scheduled buffer.
// R15: Grant withdraw before start or after lost arbitration or error.
// R16: Granted withdraw sets empty and ack; interrupt if enabled.
// R17: Software cannot clear a withdraw request; only empty setting does.
// R18: Per-buffer withdraw ack shows a successful withdraw.
// R19: Ack bits read-only; one means aborted rather than sent.
// R20: All bits registered, reset to zero except empty flags to one.
module ctab_tx_ctrl
	import ctab_pkg::*;
#(
	parameter int NBUF = CTAB_NBUF
)(
	// Clock and reset
	input  wire logic            clk_in,
	input  wire logic            reset_in,
	// Register port
	input  wire logic [3:0]      reg_addr_in,
	input  wire logic [7:0]      reg_wdata_in,
	input  wire logic            reg_wr_in,
	input  wire logic            reg_rd_in,
	output logic      [7:0]      reg_rdata_out,
	// Protocol engine
	input  wire logic [NBUF-1:0] eng_start_in,
	input  wire logic [NBUF-1:0] eng_done_in,
	input  wire logic [NBUF-1:0] eng_fail_in,
	output logic      [NBUF-1:0] eng_ready_out,
	// Buffer contents access gate
	input  wire logic [NBUF-1:0] buf_sel_in,
	output logic                 buf_access_ok_out,
	// Interrupt and mode
	input  wire logic            init_acknowledge_in,
	output logic                 tx_irq_out,
	output logic                 init_request_out,
	output logic                 listen_mode_out
);
	typedef struct packed {
		logic [NBUF-1:0] irq_en;
		logic            init_req;
		logic            listen;
		logic [7:0]      rdata;
		logic            irq;
		logic [NBUF-1:0] ready;
		logic            acc_ok;
	} ctab_top_t;

	ctab_top_t       st_ff;
	ctab_top_t       nxt_st;
	logic            in_init;
	logic            wr_ok;
	logic [NBUF-1:0] buf_empty_flag_n;
	logic [NBUF-1:0] withdraw_request_n;
	logic [NBUF-1:0] withdraw_ack_n;
	logic [NBUF-1:0] busy;
	logic [NBUF-1:0] sched;
	logic [NBUF-1:0] req_set;

	////////////////////////////////////////////////////////////////////////
	// Mode decode
	assign in_init = st_ff.init_req && init_acknowledge_in; // [R11]
	assign wr_ok   = reg_wr_in && !st_ff.init_req && !init_acknowledge_in; // [R12]

	// Write-one-to-clear of empty flags, dropped in listen mode
	assign sched   = (wr_ok && reg_addr_in == CTAB_OFS_EMPTY && !st_ff.listen) ?
	                 reg_wdata_in[NBUF-1:0] : '0; // [R2] [R9]
	// Write-one-to-set of withdraw requests
	assign req_set = (wr_ok && reg_addr_in == CTAB_OFS_ABTREQ) ?
	                 reg_wdata_in[NBUF-1:0] : '0; // [R14]

	////////////////////////////////////////////////////////////////////////
	// Per-buffer state
	genvar gi;
	generate
		for (gi = 0; gi < NBUF; gi++) begin : g_slot
			ctab_slot u_slot (
				.clk_in     (clk_in),
				.reset_in   (reset_in),
				.hold_in    (in_init),
				.sched_in   (sched[gi]),
				.req_set_in (req_set[gi]),
				.start_in   (eng_start_in[gi] && !st_ff.listen), // [R9]
				.done_in    (eng_done_in[gi]),
				.fail_in    (eng_fail_in[gi]),
				.empty_out  (buf_empty_flag_n[gi]), // [R1]
				.req_out    (withdraw_request_n[gi]),
				.ack_out    (withdraw_ack_n[gi]), // [R18]
				.busy_out   (busy[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Registers, read path and outputs
	always_comb begin
		nxt_st = st_ff;
		if (in_init)
			nxt_st.irq_en = '0; // [R11]
		else if (wr_ok && reg_addr_in == CTAB_OFS_IRQEN)
			nxt_st.irq_en = reg_wdata_in[NBUF-1:0];
		// Mode register stays writable so init can be left
		if (reg_wr_in && reg_addr_in == CTAB_OFS_MODE) begin
			nxt_st.init_req = reg_wdata_in[CTAB_MODE_INIT];
			nxt_st.listen   = reg_wdata_in[CTAB_MODE_LSTN];
		end
		// Read data only in the cycle after the strobe; ack has no write path
		nxt_st.rdata = CTAB_RD_ZERO;
		if (reg_rd_in) begin
			case (reg_addr_in)
				CTAB_OFS_EMPTY:  nxt_st.rdata = {{(8-NBUF){1'b0}}, buf_empty_flag_n};
				CTAB_OFS_IRQEN:  nxt_st.rdata = {{(8-NBUF){1'b0}}, st_ff.irq_en};
				CTAB_OFS_ABTREQ: nxt_st.rdata = {{(8-NBUF){1'b0}}, withdraw_request_n};
				CTAB_OFS_ABTACK: nxt_st.rdata = {{(8-NBUF){1'b0}}, withdraw_ack_n}; // [R19]
				CTAB_OFS_MODE:   nxt_st.rdata = {6'h00, st_ff.listen, st_ff.init_req};
				default:         nxt_st.rdata = CTAB_RD_ZERO;
			endcase
		end
		// Level interrupt from registered flags and enables
		nxt_st.irq    = |(nxt_empty_view() & st_ff.irq_en); // [R6] [R13]
		nxt_st.ready  = st_ff.listen ? '0 : ~buf_empty_flag_n & ~busy; // [R9]
		// Content access blocked while the selected buffer is scheduled
		nxt_st.acc_ok = |buf_sel_in && ((buf_sel_in & ~buf_empty_flag_n) == '0); // [R10]
	end

	// Empty view used by the interrupt
	function automatic logic [NBUF-1:0] nxt_empty_view();
		return buf_empty_flag_n;
	endfunction : nxt_empty_view

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in)
			st_ff <= '0; // [R20]
		else
			st_ff <= nxt_st;
	end

	assign reg_rdata_out     = st_ff.rdata;
	assign tx_irq_out        = st_ff.irq;
	assign eng_ready_out     = st_ff.ready;
	assign buf_access_ok_out = st_ff.acc_ok;
	assign init_request_out  = st_ff.init_req;
	assign listen_mode_out   = st_ff.listen;

	////////////////////////////////////////////////////////////////////////
	// Checks
	irq_level_a: assert property (@(posedge clk_in) disable iff (reset_in)
		##1 tx_irq_out == |($past(buf_empty_flag_n) & $past(st_ff.irq_en)))
		else $error("irq mismatch"); // [R6]
	listen_keep_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(st_ff.listen && buf_empty_flag_n[0]) |=> buf_empty_flag_n[0])
		else $error("flag cleared in listen"); // [R9]
	init_block_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(st_ff.init_req && reg_wr_in && reg_addr_in == CTAB_OFS_IRQEN)
		|=> st_ff.irq_en == $past(st_ff.irq_en) || st_ff.irq_en == '0)
		else $error("enable written in init"); // [R12]
	access_gate_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(|(buf_sel_in & ~buf_empty_flag_n)) |=> !buf_access_ok_out)
		else $error("scheduled buffer accessible"); // [R10]
	rd_empty_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(reg_rd_in && reg_addr_in == CTAB_OFS_EMPTY)
		|=> reg_rdata_out[NBUF-1:0] == $past(buf_empty_flag_n))
		else $error("empty read wrong"); // [R2]
	cov_irq_c: cover property (@(posedge clk_in) disable iff (reset_in) $rose(tx_irq_out));
	cov_init_c: cover property (@(posedge clk_in) disable iff (reset_in) in_init);
endmodule : ctab_tx_ctrl

/* inc/ctab_pkg.sv */
package ctab_pkg;
	// Register offsets on the plain register port
	localparam logic [3:0] CTAB_OFS_EMPTY  = 4'h0;
	localparam logic [3:0] CTAB_OFS_IRQEN  = 4'h1;
	localparam logic [3:0] CTAB_OFS_ABTREQ = 4'h2;
	localparam logic [3:0] CTAB_OFS_ABTACK = 4'h3;
	localparam logic [3:0] CTAB_OFS_MODE   = 4'h4;
	// Field layout
	localparam int         CTAB_NBUF       = 3;
	localparam int         CTAB_MODE_INIT  = 0;
	localparam int         CTAB_MODE_LSTN  = 1;
	// Reset values
	localparam logic [2:0] CTAB_RST_EMPTY  = 3'h7;
	localparam logic [2:0] CTAB_RST_ZERO   = 3'h0;
	localparam logic [7:0] CTAB_RD_ZERO    = 8'h00;
	// Per-buffer transmit phase
	typedef enum logic [2:0] {
		CTAB_ST_IDLE = 3'b001,
		CTAB_ST_PEND = 3'b010,
		CTAB_ST_BUSY = 3'b100
	} ctab_phase_t;
endpackage : ctab_pkg

/* rtl/ctab_slot.sv */
`timescale 1ns/1ps
// One transmit buffer: empty flag, withdraw request and withdraw ack
module ctab_slot
	import ctab_pkg::*;
(
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic reset_in,
	// Control
	input  wire logic hold_in,
	input  wire logic sched_in,
	input  wire logic req_set_in,
	input  wire logic start_in,
	input  wire logic done_in,
	input  wire logic fail_in,
	// State
	output logic      empty_out,
	output logic      req_out,
	output logic      ack_out,
	output logic      busy_out
);
	typedef struct packed {
		logic        empty;
		logic        req;
		logic        ack;
		ctab_phase_t ph;
	} ctab_slot_t;

	ctab_slot_t st_ff;
	ctab_slot_t nxt_st;
	logic       grant;

	// Next state; completion and abort win over a same-cycle schedule
	always_comb begin
		nxt_st = st_ff;
		grant  = 1'b0;
		if (hold_in) begin
			nxt_st.empty = 1'b1; // [R11]
			nxt_st.req   = 1'b0;
			nxt_st.ack   = 1'b0;
			nxt_st.ph    = CTAB_ST_IDLE;
		end else begin
			if (req_set_in && !st_ff.empty)
				nxt_st.req = 1'b1; // [R17]
			// Grant before start, or after a failed attempt
			grant = (st_ff.req || req_set_in) && !st_ff.empty &&
			        ((st_ff.ph == CTAB_ST_PEND && !start_in) ||
			         (st_ff.ph == CTAB_ST_BUSY && fail_in)); // [R15]
			if (st_ff.ph == CTAB_ST_BUSY && done_in) begin
				nxt_st.empty = 1'b1; // [R4]
				nxt_st.req   = 1'b0; // [R8]
				nxt_st.ph    = CTAB_ST_IDLE;
			end else if (grant) begin
				nxt_st.empty = 1'b1; // [R5]
				nxt_st.ack   = 1'b1; // [R16]
				nxt_st.req   = 1'b0; // [R8]
				nxt_st.ph    = CTAB_ST_IDLE;
			end else begin
				if (st_ff.ph == CTAB_ST_PEND && start_in)
					nxt_st.ph = CTAB_ST_BUSY;
				else if (st_ff.ph == CTAB_ST_BUSY && fail_in)
					nxt_st.ph = CTAB_ST_PEND; // Retry later
				if (sched_in && st_ff.empty) begin
					nxt_st.empty = 1'b0; // [R2]
					nxt_st.ack   = 1'b0; // [R7]
					nxt_st.ph    = CTAB_ST_PEND;
				end
			end
		end
	end

	// State register
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in)
			st_ff <= '{empty: 1'b1, req: 1'b0, ack: 1'b0, ph: CTAB_ST_IDLE}; // [R20]
		else
			st_ff <= nxt_st;
	end

	assign empty_out = st_ff.empty;
	assign req_out   = st_ff.req;
	assign ack_out   = st_ff.ack;
	assign busy_out  = (st_ff.ph == CTAB_ST_BUSY);

	////////////////////////////////////////////////////////////////////////
	// Checks
	empty_req_a: assert property (@(posedge clk_in) disable iff (reset_in)
		$rose(st_ff.empty) |-> !st_ff.req) else $error("req kept after empty"); // [R8]
	clear_ack_a: assert property (@(posedge clk_in) disable iff (reset_in)
		$fell(st_ff.empty) |-> !st_ff.ack) else $error("ack kept on schedule"); // [R7]
	ack_empty_a: assert property (@(posedge clk_in) disable iff (reset_in)
		st_ff.ack |-> st_ff.empty) else $error("ack without empty"); // [R16]
	done_empty_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(busy_out && done_in && !hold_in) |=> st_ff.empty && !st_ff.ack)
		else $error("send did not empty"); // [R4]
	hold_rst_a: assert property (@(posedge clk_in) disable iff (reset_in)
		hold_in |=> st_ff.empty && !st_ff.req && !st_ff.ack) else $error("hold failed"); // [R11]
	abort_pend_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(st_ff.req && st_ff.ph == CTAB_ST_PEND && !start_in && !hold_in)
		|=> st_ff.empty && st_ff.ack) else $error("abort not granted"); // [R15]
	req_keep_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(st_ff.req && !nxt_st.empty && !hold_in) |=> st_ff.req)
		else $error("req dropped early"); // [R17]
	cov_abort_c: cover property (@(posedge clk_in) disable iff (reset_in) $rose(st_ff.ack));
	cov_sent_c: cover property (@(posedge clk_in) disable iff (reset_in)
		busy_out && done_in);
	cov_retry_c: cover property (@(posedge clk_in) disable iff (reset_in)
		busy_out && fail_in && !st_ff.req);
endmodule : ctab_slot

/* verif/ctab_eng_model.sv */
`timescale 1ns/1ps
// Protocol engine stand-in: picks the lowest ready buffer, then reports done or fail
module ctab_eng_model
	import ctab_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       reset_in,
	// Test control
	input  wire logic       run_in,
	input  wire logic       fail_mode_in,
	input  wire logic [3:0] delay_in,
	// Engine side of the block
	input  wire logic [2:0] ready_in,
	output logic      [2:0] start_out,
	output logic      [2:0] done_out,
	output logic      [2:0] fail_out
);
	logic       busy_ff;
	logic [3:0] cnt_ff;
	logic [2:0] sel_ff;
	////////////////////////////////////////////////////////////////////////////////
	// One frame at a time; a slow delay leaves room for a withdraw mid-frame
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			busy_ff   <= 1'b0;
			cnt_ff    <= 4'h0;
			sel_ff    <= 3'h0;
			start_out <= 3'h0;
			done_out  <= 3'h0;
			fail_out  <= 3'h0;
		end else begin
			start_out <= 3'h0;
			done_out  <= 3'h0;
			fail_out  <= 3'h0;
			if (!busy_ff && run_in && |ready_in) begin
				busy_ff   <= 1'b1;
				cnt_ff    <= delay_in;
				sel_ff    <= ready_in & (~ready_in + 3'h1);
				start_out <= ready_in & (~ready_in + 3'h1);
			end else if (busy_ff && cnt_ff == 4'h0) begin
				busy_ff <= 1'b0;
				// Lost arbitration or error when asked for
				if (fail_mode_in) begin
					fail_out <= sel_ff;
				end else begin
					done_out <= sel_ff;
				end
			end else if (busy_ff) begin
				cnt_ff <= cnt_ff - 4'h1;
			end
		end
	end
endmodule : ctab_eng_model

/* verif/tb_can_tx_buffer_abort_control.sv */
`timescale 1ns/1ps
module tb_can_tx_buffer_abort_control;
	import ctab_pkg::*;
	logic       clk_in, reset_in, reg_wr, reg_rd, init_ack, run, fmode, irq, acc_ok;
	logic [3:0] addr, dly;
	logic [7:0] wdata, rdata;
	logic [2:0] start, done, fail, ready, sel;
	int         bad_count = 0;
	int         compares = 0;
	ctab_tx_ctrl ctab_tx_ctrl_i (.clk_in(clk_in), .reset_in(reset_in), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(rdata),
		.eng_start_in(start), .eng_done_in(done), .eng_fail_in(fail), .eng_ready_out(ready),
		.buf_sel_in(sel), .buf_access_ok_out(acc_ok), .init_acknowledge_in(init_ack),
		.tx_irq_out(irq), .init_request_out(), .listen_mode_out());
	ctab_eng_model ctab_eng_model_i (.clk_in(clk_in), .reset_in(reset_in), .run_in(run),
		.fail_mode_in(fmode), .delay_in(dly), .ready_in(ready), .start_out(start),
		.done_out(done), .fail_out(fail));
	////////////////////////////////////////////////////////////////////////////////
	// Clock
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	// Shared compare, reporting and register access
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_in);
		reg_wr <= 1'b1;
		addr   <= a;
		wdata  <= d;
		@(posedge clk_in);
		reg_wr <= 1'b0;
	endtask : wr
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk_in);
		reg_rd <= 1'b1;
		addr   <= a;
		@(posedge clk_in);
		reg_rd <= 1'b0;
		@(negedge clk_in);
		chk(rdata, exp);
	endtask : rd
	task automatic stop_test();
		$display("bad_count=%0d compares=%0d", bad_count, compares);
		if (bad_count == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : stop_test
	// Watchdog: the sequence needs well under 1000 cycles
	initial begin
		#50000;
		bad_count++;
		stop_test();
	end
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{reg_wr, reg_rd, init_ack, run, fmode} = 5'h00;
		addr     = 4'h0;
		wdata    = 8'h00;
		dly      = 4'h2;
		sel      = 3'h0;
		reset_in = 1'b1;
		repeat (16) @(posedge clk_in);
		reset_in <= 1'b0;
		rd(CTAB_OFS_EMPTY, 8'h07);
		rd(CTAB_OFS_IRQEN, 8'h00);
		rd(CTAB_OFS_ABTREQ, 8'h00);
		rd(4'hF, 8'h00);
		// Interrupt follows empty flag and its enable
		wr(CTAB_OFS_IRQEN, 8'h01);
		repeat (2) @(negedge clk_in);
		chk({7'h00, irq}, 8'h01);
		wr(CTAB_OFS_EMPTY, 8'h01);
		wr(CTAB_OFS_EMPTY, 8'h00);
		rd(CTAB_OFS_EMPTY, 8'h06);
		chk({7'h00, irq}, 8'h00);
		// Withdraw of a pending message before any start
		wr(CTAB_OFS_ABTREQ, 8'h01);
		rd(CTAB_OFS_EMPTY, 8'h07);
		rd(CTAB_OFS_ABTACK, 8'h01);
		rd(CTAB_OFS_ABTREQ, 8'h00);
		chk({7'h00, irq}, 8'h01);
		wr(CTAB_OFS_ABTACK, 8'h00);
		rd(CTAB_OFS_ABTACK, 8'h01);
		wr(CTAB_OFS_EMPTY, 8'h01);
		rd(CTAB_OFS_ABTACK, 8'h00);
		// Content access gate
		@(posedge clk_in);
		sel <= 3'h1;
		repeat (2) @(negedge clk_in);
		chk({7'h00, acc_ok}, 8'h00);
		@(posedge clk_in);
		sel <= 3'h2;
		repeat (2) @(negedge clk_in);
		chk({7'h00, acc_ok}, 8'h01);
		// Successful sends, two buffers in a row
		run <= 1'b1;
		wr(CTAB_OFS_EMPTY, 8'h04);
		repeat (20) @(posedge clk_in);
		rd(CTAB_OFS_EMPTY, 8'h07);
		rd(CTAB_OFS_ABTACK, 8'h00);
		// Withdraw while sending, then the frame fails
		fmode <= 1'b1;
		dly   <= 4'hF;
		wr(CTAB_OFS_EMPTY, 8'h02);
		repeat (3) @(posedge clk_in);
		wr(CTAB_OFS_ABTREQ, 8'h02);
		rd(CTAB_OFS_ABTREQ, 8'h02);
		wr(CTAB_OFS_ABTREQ, 8'h00);
		rd(CTAB_OFS_ABTREQ, 8'h02);
		repeat (20) @(posedge clk_in);
		rd(CTAB_OFS_EMPTY, 8'h07);
		rd(CTAB_OFS_ABTACK, 8'h02);
		rd(CTAB_OFS_ABTREQ, 8'h00);
		// Listen mode refuses scheduling
		run <= 1'b0;
		wr(CTAB_OFS_MODE, 8'h02);
		wr(CTAB_OFS_EMPTY, 8'h07);
		rd(CTAB_OFS_EMPTY, 8'h07);
		wr(CTAB_OFS_MODE, 8'h00);
		// Init mode holds and refuses
		wr(CTAB_OFS_IRQEN, 8'h07);
		wr(CTAB_OFS_EMPTY, 8'h01);
		wr(CTAB_OFS_MODE, 8'h01);
		init_ack <= 1'b1;
		rd(CTAB_OFS_EMPTY, 8'h07);
		rd(CTAB_OFS_ABTACK, 8'h00);
		wr(CTAB_OFS_IRQEN, 8'h07);
		rd(CTAB_OFS_IRQEN, 8'h00);
		init_ack <= 1'b0;
		wr(CTAB_OFS_IRQEN, 8'h03);
		rd(CTAB_OFS_IRQEN, 8'h00);
		wr(CTAB_OFS_MODE, 8'h00);
		wr(CTAB_OFS_IRQEN, 8'h03);
		rd(CTAB_OFS_IRQEN, 8'h03);
		stop_test();
	end
endmodule : tb_can_tx_buffer_abort_control
